// *** inc/ncr_cfg.svh ***
// Constants for the negate, call and return execution unit.
// Included by the design and bench files; holds definitions only.
`ifndef NCR_CFG_SVH
`define NCR_CFG_SVH
// Register byte offsets on the APB
`define NCR_OFF_CTRL 8'h00
`define NCR_OFF_INSTR 8'h04
`define NCR_OFF_STAT 8'h08
`define NCR_OFF_ACC 8'h0C
`define NCR_OFF_FLAGS 8'h10
`define NCR_OFF_BANK 8'h14
`define NCR_OFF_PC 8'h18
`define NCR_OFF_SHADOW 8'h1C
`define NCR_OFF_IRQEN 8'h20
`define NCR_OFF_STACK 8'h24
`define NCR_OFF_FSR2 8'h28
// Status flag bit positions
`define NCR_FLG_C 0
`define NCR_FLG_HALF 1
`define NCR_FLG_Z 2
`define NCR_FLG_EXCESS 3
`define NCR_FLG_N 4
// Reset values
`define NCR_RST_ACC 8'h00
`define NCR_RST_FLAGS 5'h00
`define NCR_RST_BANK 4'h0
`define NCR_RST_PC 21'h000000
`define NCR_RST_IRQEN 2'h0
`define NCR_RST_FSR 12'h000
// Opcode fields
`define NCR_OP_NEG_FILE 7'h36
`define NCR_OP_ROT_CARRY 6'h0D
`define NCR_OP_REL_CALL 5'h1B
`define NCR_OP_LIT_RET 8'h0C
`define NCR_OP_IRQ_RET 15'h0008
`define NCR_OP_RETURN 15'h0009
`define NCR_OP_RESET 16'h00FF
// Addressing, stack and timing
`define NCR_ACC_LIM 8'h5F
`define NCR_ACC_HI 4'hF
`define NCR_STK_DEPTH 5'd31
`define NCR_PC_STEP 21'h000002
`define NCR_Q_ADDR 2'h0
`define NCR_Q_READ 2'h2
`define NCR_Q_LAST 2'h3
`define NCR_IRQ_HI 2'h1
`define NCR_IRQ_LO 2'h2
`endif

// *** inc/ncr_pkg.sv ***
// Types shared by the execution unit and its flag calculator.
// Assumes ncr_cfg.svh for numeric constants.
`default_nettype none
package ncr_pkg;
    typedef enum logic [2:0] {ST_IDLE = 3'h1, ST_EXEC = 3'h2, ST_WAIT = 3'h4} ncr_state_t;
    typedef enum logic [3:0] {
        OP_ILL = 4'h0, OP_NEG_FILE = 4'h1, OP_ROT_CARRY = 4'h2, OP_REL_CALL = 4'h3,
        OP_RESET = 4'h4, OP_RETURN = 4'h5, OP_IRQ_RET = 4'h6, OP_LIT_RET = 4'h7
    } ncr_op_t;
    typedef struct packed {logic rot; logic [7:0] opnd; logic [4:0] flags;} ncr_alu_in_t;
    typedef struct packed {logic [7:0] res; logic [4:0] flags;} ncr_alu_out_t;
endpackage
`default_nettype wire

// *** design/ncr_alu.sv ***
// Result and flag calculator for negate and rotate-through-carry.
// Purely combinational; the caller registers operand and result.
`timescale 1ns/1ns
`default_nettype none
`include "ncr_cfg.svh"
module ncr_alu
    import ncr_pkg::*;
(
    input wire ncr_alu_in_t alu_i,
    output var ncr_alu_out_t alu_o
);
    logic [8:0] sum;
    logic [4:0] nib;
    logic [7:0] res;
    logic [4:0] flg;

    // Negate as ~f + 1 so carry and half carry fall out of the adder
    always_comb
    begin
        sum = {1'b0, ~alu_i.opnd} + 9'h001;
        nib = {1'b0, ~alu_i.opnd[3:0]} + 5'h01;
        flg = alu_i.flags;
        if (alu_i.rot)
        begin
            res = {alu_i.opnd[6:0], alu_i.flags[`NCR_FLG_C]};
            flg[`NCR_FLG_C] = alu_i.opnd[7];
        end
        else
        begin
            res = sum[7:0];
            flg[`NCR_FLG_C] = sum[8];
            flg[`NCR_FLG_HALF] = nib[4];
            flg[`NCR_FLG_EXCESS] = (alu_i.opnd == 8'h80); // Only -128 has no positive counterpart
        end
        flg[`NCR_FLG_N] = res[7];
        flg[`NCR_FLG_Z] = (res == 8'h00);
        alu_o = {res, flg};
    end
endmodule // ncr_alu
`default_nettype wire

// *** design/ncr_exec.sv ***
// Execution unit for negate, relative call, software reset and returns.
// Assumes an APB master and a data memory answering within two clocks.
//
// Overview of operation
// - Negate writes two's complement, updates five flags
// - Negate writes file itself, one instruction cycle
// - Access bit one selects bank register bank
// - Extended mode, low offsets index from FSR2
// - Call offset is eleven-bit signed
// - Call pushes counter plus two first
// - Call target is counter plus two plus 2n
// - Call takes two cycles, second idle
// - Reset instruction starts master clear reset
// - Reset restores all affected registers; the code leaves the shadows and the CTRL mode bit unchanged
// - Return pops; fast bit restores shadows
// - Fast bit zero leaves accumulator untouched
// - Interrupt return pops, sets a global enable
`timescale 1ns/1ns
`default_nettype none
`include "ncr_cfg.svh"
module ncr_exec
    import ncr_pkg::*;
(
    input wire logic CLK_SYS_I,
    input wire logic RST_B_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    output logic [11:0] DM_ADDR_O,
    output logic [7:0] DM_WDATA_O,
    output logic DM_WE_O,
    input wire logic [7:0] DM_RDATA_I,
    output logic SOFT_RST_O
);
    ncr_state_t state_reg;
    ncr_op_t op;
    logic [1:0] q_reg;
    logic [15:0] ir_reg;
    logic [15:0] pend_word_reg;
    logic pend_reg;
    logic ext_en_reg;
    logic [7:0] acc_reg;
    logic [7:0] shadow_acc_reg;
    logic [4:0] flags_reg;
    logic [4:0] fs_reg;
    logic [3:0] bank_reg;
    logic [3:0] bs_reg;
    logic [20:0] pc_reg;
    logic [1:0] irqen_reg;
    logic [11:0] fsr2_reg;
    logic [20:0] stk_mem [0:`NCR_STK_DEPTH-1];
    logic [4:0] sp_reg;
    logic [20:0] stack_top;
    logic [7:0] opnd_reg;
    logic [2:0] sticky_reg;
    logic [2:0] sticky_set;
    logic [31:0] rd_data;
    logic q_last, commit, soft_clr, busy, to_file, two_cyc, is_pop, wr_ok, apb_err_reg;
    ncr_alu_in_t alu_in;
    ncr_alu_out_t alu_out;

    function automatic ncr_op_t op_of(input logic [15:0] w);
        return (w[15:9] == `NCR_OP_NEG_FILE) ? OP_NEG_FILE :
               (w[15:10] == `NCR_OP_ROT_CARRY) ? OP_ROT_CARRY :
               (w[15:11] == `NCR_OP_REL_CALL) ? OP_REL_CALL :
               (w == `NCR_OP_RESET) ? OP_RESET :
               (w[15:1] == `NCR_OP_RETURN) ? OP_RETURN :
               (w[15:1] == `NCR_OP_IRQ_RET) ? OP_IRQ_RET :
               (w[15:8] == `NCR_OP_LIT_RET) ? OP_LIT_RET : OP_ILL;
    endfunction

    // Effective data address of a file operand
    function automatic logic [11:0] ea_of(input logic [15:0] w, input logic [3:0] bank,
                                          input logic ext, input logic [11:0] fsr);
        if (w[8])
            return {bank, w[7:0]};
        else if (ext && (w[7:0] <= `NCR_ACC_LIM))
            return fsr + {4'h0, w[7:0]};
        else if (w[7:0] <= `NCR_ACC_LIM)
            return {4'h0, w[7:0]};
        else
            return {`NCR_ACC_HI, w[7:0]};
    endfunction

    // Refusal of an access; unmapped always, most writes only while busy
    function automatic logic err_of(input logic [7:0] a, input logic wr, input logic bsy,
                                    input logic pnd);
        if (!(a inside {`NCR_OFF_CTRL, `NCR_OFF_INSTR, `NCR_OFF_STAT, `NCR_OFF_ACC,
                        `NCR_OFF_FLAGS, `NCR_OFF_BANK, `NCR_OFF_PC, `NCR_OFF_SHADOW,
                        `NCR_OFF_IRQEN, `NCR_OFF_STACK, `NCR_OFF_FSR2}))
            return 1'b1;
        else if (!wr || (a == `NCR_OFF_STAT))
            return 1'b0;
        else if (a == `NCR_OFF_INSTR)
            return pnd;
        else if (a == `NCR_OFF_STACK)
            return 1'b1;
        else
            return bsy;
    endfunction

    // Decode and shared strobes
    assign op = op_of(ir_reg);
    assign q_last = (q_reg == `NCR_Q_LAST);
    assign commit = (state_reg == ST_EXEC) && q_last;
    assign soft_clr = commit && (op == OP_RESET);
    assign busy = (state_reg != ST_IDLE) || pend_reg;
    assign to_file = (op == OP_NEG_FILE) || ((op == OP_ROT_CARRY) && ir_reg[9]);
    assign is_pop = (op == OP_RETURN) || (op == OP_IRQ_RET) || (op == OP_LIT_RET);
    assign two_cyc = is_pop || (op == OP_REL_CALL);
    assign stack_top = (sp_reg == 5'h00) ? `NCR_RST_PC : stk_mem[sp_reg - 5'h01];
    assign alu_in = {op == OP_ROT_CARRY, opnd_reg, flags_reg};

    ncr_alu u_alu (
        .alu_i(alu_in),
        .alu_o(alu_out)
    );

    // Quarter counter; q_last is the instruction-cycle enable
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
            q_reg <= 2'h0;
        else
            q_reg <= q_reg + 2'h1;
    end

    // Sequencer: an instruction starts only on a cycle boundary
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            state_reg <= ST_IDLE;
            ir_reg <= 16'h0000;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                    if (pend_reg && q_last)
                    begin
                        state_reg <= ST_EXEC;
                        ir_reg <= pend_word_reg;
                    end
                ST_EXEC:
                    if (q_last)
                        state_reg <= two_cyc ? ST_WAIT : ST_IDLE;
                ST_WAIT:
                    if (q_last)
                        state_reg <= ST_IDLE;
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    // One-deep instruction slot; lets software queue while one executes
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            pend_reg <= 1'b0;
            pend_word_reg <= 16'h0000;
        end
        else if (wr_ok && (PADDR_I == `NCR_OFF_INSTR))
        begin
            pend_reg <= 1'b1;
            pend_word_reg <= PWDATA_I[15:0];
        end
        else if ((state_reg == ST_IDLE) && q_last)
            pend_reg <= 1'b0;
    end

    // Data memory side: address in Q1, operand in Q3, write after commit
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            DM_ADDR_O <= 12'h000;
            DM_WDATA_O <= 8'h00;
            DM_WE_O <= 1'b0;
            opnd_reg <= 8'h00;
        end
        else
        begin
            DM_WE_O <= commit && to_file;
            if ((state_reg == ST_EXEC) && (q_reg == `NCR_Q_ADDR))
                DM_ADDR_O <= ea_of(ir_reg, bank_reg, ext_en_reg, fsr2_reg);
            if ((state_reg == ST_EXEC) && (q_reg == `NCR_Q_READ))
                opnd_reg <= DM_RDATA_I;
            if (commit)
                DM_WDATA_O <= alu_out.res;
        end
    end

    // Accumulator, flags and bank select; software owns them only while idle
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            acc_reg <= `NCR_RST_ACC;
            flags_reg <= `NCR_RST_FLAGS;
            bank_reg <= `NCR_RST_BANK;
        end
        else if (soft_clr)
        begin
            acc_reg <= `NCR_RST_ACC;
            flags_reg <= `NCR_RST_FLAGS;
            bank_reg <= `NCR_RST_BANK;
        end
        else if (commit)
        begin
            case (op)
                OP_NEG_FILE:
                    flags_reg <= alu_out.flags;
                OP_ROT_CARRY:
                begin
                    flags_reg <= alu_out.flags;
                    if (!ir_reg[9])
                        acc_reg <= alu_out.res;
                end
                OP_LIT_RET:
                    acc_reg <= ir_reg[7:0];
                OP_RETURN, OP_IRQ_RET:
                    if (ir_reg[0])
                    begin
                        acc_reg <= shadow_acc_reg;
                        flags_reg <= fs_reg;
                        bank_reg <= bs_reg;
                    end
                default:
                    acc_reg <= acc_reg;
            endcase
        end
        else if (wr_ok)
        begin
            case (PADDR_I)
                `NCR_OFF_ACC:
                    acc_reg <= PWDATA_I[7:0];
                `NCR_OFF_FLAGS:
                    flags_reg <= PWDATA_I[4:0];
                `NCR_OFF_BANK:
                    bank_reg <= PWDATA_I[3:0];
                default:
                    acc_reg <= acc_reg;
            endcase
        end
    end

    // Shadows, interrupt enables, index base and mode; only an APB write fills shadows
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            {shadow_acc_reg, fs_reg, bs_reg} <= {`NCR_RST_ACC, `NCR_RST_FLAGS, `NCR_RST_BANK};
            irqen_reg <= `NCR_RST_IRQEN;
            fsr2_reg <= `NCR_RST_FSR;
            ext_en_reg <= 1'b0;
        end
        else if (soft_clr)
        begin
            irqen_reg <= `NCR_RST_IRQEN;
            fsr2_reg <= `NCR_RST_FSR;
        end
        else if (commit && (op == OP_IRQ_RET))
            irqen_reg <= irqen_reg | (irqen_reg[0] ? `NCR_IRQ_LO : `NCR_IRQ_HI);
        else if (wr_ok && (PADDR_I == `NCR_OFF_SHADOW))
            {bs_reg, fs_reg, shadow_acc_reg} <= {PWDATA_I[19:16], PWDATA_I[12:8], PWDATA_I[7:0]};
        else if (wr_ok && (PADDR_I == `NCR_OFF_IRQEN))
            irqen_reg <= PWDATA_I[1:0];
        else if (wr_ok && (PADDR_I == `NCR_OFF_FSR2))
            fsr2_reg <= PWDATA_I[11:0];
        else if (wr_ok && (PADDR_I == `NCR_OFF_CTRL))
            ext_en_reg <= PWDATA_I[0];
    end

    // Program counter and stack pointer; a full or empty stack is flagged
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            pc_reg <= `NCR_RST_PC;
            sp_reg <= 5'h00;
        end
        else if (soft_clr)
        begin
            pc_reg <= `NCR_RST_PC;
            sp_reg <= 5'h00;
        end
        else if (commit && (op == OP_REL_CALL))
        begin
            pc_reg <= pc_reg + `NCR_PC_STEP + {{9{ir_reg[10]}}, ir_reg[10:0], 1'b0};
            if (sp_reg < `NCR_STK_DEPTH)
                sp_reg <= sp_reg + 5'h01;
        end
        else if (commit && is_pop)
        begin
            pc_reg <= stack_top;
            if (sp_reg != 5'h00)
                sp_reg <= sp_reg - 5'h01;
        end
        else if (commit)
            pc_reg <= pc_reg + `NCR_PC_STEP;
        else if (wr_ok && (PADDR_I == `NCR_OFF_PC))
            pc_reg <= {PWDATA_I[20:1], 1'b0};
    end

    // Stack storage; the push lands on the same edge the counter moves, from its old value
    always_ff @(posedge CLK_SYS_I)
    begin
        if (commit && (op == OP_REL_CALL) && (sp_reg < `NCR_STK_DEPTH))
            stk_mem[sp_reg] <= pc_reg + `NCR_PC_STEP;
    end

    // Sticky status: illegal word, stack fault, software reset; set beats clear
    assign sticky_set = {soft_clr,
                         commit && (((op == OP_REL_CALL) && (sp_reg == `NCR_STK_DEPTH)) ||
                                    (is_pop && (sp_reg == 5'h00))),
                         commit && (op == OP_ILL)};
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
            sticky_reg <= 3'h0;
        else if (wr_ok && (PADDR_I == `NCR_OFF_STAT))
            sticky_reg <= (sticky_reg & ~PWDATA_I[4:2]) | sticky_set;
        else
            sticky_reg <= sticky_reg | sticky_set;
    end

    // Software reset strobe for the rest of the chip
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
            SOFT_RST_O <= 1'b0;
        else
            SOFT_RST_O <= soft_clr;
    end

    // Read mux
    always_comb
    begin
        case (PADDR_I)
            `NCR_OFF_CTRL: rd_data = {31'h0, ext_en_reg};
            `NCR_OFF_INSTR: rd_data = {16'h0, pend_word_reg};
            `NCR_OFF_STAT: rd_data = {27'h0, sticky_reg, pend_reg, state_reg != ST_IDLE};
            `NCR_OFF_ACC: rd_data = {24'h0, acc_reg};
            `NCR_OFF_FLAGS: rd_data = {27'h0, flags_reg};
            `NCR_OFF_BANK: rd_data = {28'h0, bank_reg};
            `NCR_OFF_PC: rd_data = {11'h0, pc_reg};
            `NCR_OFF_SHADOW: rd_data = {12'h0, bs_reg, 3'h0, fs_reg, shadow_acc_reg};
            `NCR_OFF_IRQEN: rd_data = {30'h0, irqen_reg};
            `NCR_OFF_STACK: rd_data = {3'h0, sp_reg, 3'h0, stack_top};
            `NCR_OFF_FSR2: rd_data = {20'h0, fsr2_reg};
            default: rd_data = 32'h0;
        endcase
    end

    // APB: data and refusal latched in setup, so the access phase needs no wait
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = apb_err_reg && PSEL_I && PENABLE_I;
    assign wr_ok = PSEL_I && PENABLE_I && PWRITE_I && !apb_err_reg;
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            PRDATA_O <= 32'h0;
            apb_err_reg <= 1'b0;
        end
        else if (PSEL_I && !PENABLE_I)
        begin
            PRDATA_O <= PWRITE_I ? 32'h0 : rd_data;
            apb_err_reg <= err_of(PADDR_I, PWRITE_I, busy, pend_reg);
        end
    end

    // Checks
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RST_B_I);

    property p_neg_val;
        commit && (op == OP_NEG_FILE) |=> DM_WE_O && (DM_WDATA_O == 8'h00 - $past(opnd_reg));
    endproperty
    a_neg_val: assert property (p_neg_val) else $error("negate result wrong");

    property p_neg_one;
        commit && (op == OP_NEG_FILE) |=> (state_reg == ST_IDLE) && $stable(acc_reg);
    endproperty
    a_neg_one: assert property (p_neg_one) else $error("negate not single cycle");

    property p_bank;
        (state_reg == ST_EXEC) && (q_reg == `NCR_Q_ADDR) && ir_reg[8]
            |=> DM_ADDR_O == {$past(bank_reg), $past(ir_reg[7:0])};
    endproperty
    a_bank: assert property (p_bank) else $error("bank address wrong");

    property p_index;
        (state_reg == ST_EXEC) && (q_reg == `NCR_Q_ADDR) && !ir_reg[8] && ext_en_reg
            && (ir_reg[7:0] <= `NCR_ACC_LIM) |=> DM_ADDR_O == $past(fsr2_reg) + {4'h0, $past(ir_reg[7:0])};
    endproperty
    a_index: assert property (p_index) else $error("indexed address wrong");

    property p_call_push;
        commit && (op == OP_REL_CALL) && (sp_reg < `NCR_STK_DEPTH)
            |=> (stack_top == $past(pc_reg) + `NCR_PC_STEP) && (sp_reg == $past(sp_reg) + 5'h01);
    endproperty
    a_call_push: assert property (p_call_push) else $error("call push wrong");

    property p_call_two;
        commit && (op == OP_REL_CALL) |=> (state_reg == ST_WAIT)[*4] ##1 (state_reg == ST_IDLE);
    endproperty
    a_call_two: assert property (p_call_two) else $error("call not two cycles");

    property p_soft;
        soft_clr |=> SOFT_RST_O && (pc_reg == `NCR_RST_PC) && (sp_reg == 5'h00) && (acc_reg == `NCR_RST_ACC);
    endproperty
    a_soft: assert property (p_soft) else $error("software reset incomplete");

    property p_fast;
        commit && (op == OP_RETURN) && ir_reg[0]
            |=> (acc_reg == $past(shadow_acc_reg)) && (bank_reg == $past(bs_reg));
    endproperty
    a_fast: assert property (p_fast) else $error("fast return restore wrong");

    property p_irq_ret;
        commit && (op == OP_IRQ_RET) |=> (irqen_reg != `NCR_RST_IRQEN) && (pc_reg == $past(stack_top));
    endproperty
    a_irq_ret: assert property (p_irq_ret) else $error("interrupt return wrong");

    property p_rot_carry;
        commit && (op == OP_ROT_CARRY) && !ir_reg[9]
            |=> acc_reg == {$past(opnd_reg[6:0]), $past(flags_reg[`NCR_FLG_C])};
    endproperty
    a_rot_carry: assert property (p_rot_carry) else $error("rotate result wrong");

    c_call: cover property (commit && (op == OP_REL_CALL));
    c_irq_ret: cover property (commit && (op == OP_IRQ_RET) && ir_reg[0]);
    c_reset: cover property (soft_clr);
endmodule // ncr_exec
`default_nettype wire

// *** dv/ncr_dmem_model.sv ***
// Behavioural data memory on the far side of the execution unit.
// Assumes the unit holds an address for two clocks before sampling.
`timescale 1ns/1ns
`default_nettype none
module ncr_dmem_model
(
    input wire logic clk_i,
    input wire logic [11:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic we_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem [0:4095];

    // One clock read latency; data for a new address is not there any earlier
    always @(posedge clk_i)
    begin
        rdata_o <= mem[addr_i];
        if (we_i === 1'b1)
            mem[addr_i] <= wdata_i;
    end
endmodule // ncr_dmem_model
`default_nettype wire

// *** dv/ncr_exec_tb.sv ***
// Self-checking bench for the negate, call and return unit.
// Assumes the data memory model and zero-wait APB access.
`timescale 1ns/1ns
`default_nettype none
`include "ncr_cfg.svh"
module ncr_exec_tb;
    import ncr_pkg::*;
    logic clk, rst_b, psel, penable, pwrite, pready, pslverr, we, srst, e;
    logic [7:0] paddr, wd, rd;
    logic [11:0] dma;
    logic [31:0] pwdata, prdata, q;
    int num_errors, n_checks, cyc, n_srst, i;
    // Negate cases: operand, result, flags, access bit, file, extended mode, address
    logic [7:0] opv [4] = '{8'h3A, 8'h00, 8'h80, 8'h01};
    logic [7:0] res [4] = '{8'hC6, 8'h00, 8'h80, 8'hFF};
    logic [4:0] flg [4] = '{5'h10, 5'h07, 5'h1A, 5'h10};
    logic abit [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
    logic [7:0] fo [4] = '{8'h05, 8'h10, 8'h10, 8'h60};
    logic ext [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
    logic [11:0] ea [4] = '{12'h005, 12'h310, 12'h210, 12'hF60};
    logic [7:0] rz [7] = '{`NCR_OFF_ACC, `NCR_OFF_FLAGS, `NCR_OFF_BANK, `NCR_OFF_PC,
        `NCR_OFF_IRQEN, `NCR_OFF_FSR2, `NCR_OFF_STACK};

    ncr_exec DUT (.CLK_SYS_I(clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .DM_ADDR_O(dma), .DM_WDATA_O(wd), .DM_WE_O(we), .DM_RDATA_I(rd), .SOFT_RST_O(srst));
    ncr_dmem_model DMEM (.clk_i(clk), .addr_i(dma), .wdata_i(wd), .we_i(we), .rdata_o(rd));

    // 20 MHz system clock
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Cycle ceiling cuts a hang short; soft reset pulses are counted here
    always @(posedge clk)
    begin
        cyc++;
        if (srst === 1'b1)
            n_srst++;
        if (cyc == 30000)
        begin
            num_errors++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // One APB transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        n_checks++;
        if (g !== x)
        begin
            $display("BAD %s expected %h seen %h", nm, x, g);
            num_errors++;
        end
    endtask

    task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(nm, x, q);
    endtask

    // Issue one word and poll status until neither executing nor pending
    task automatic run(input logic [15:0] w);
        int k;
        apb(1'b1, `NCR_OFF_INSTR, {16'h0000, w});
        k = 0;
        do
        begin
            apb(1'b0, `NCR_OFF_STAT, 32'h0);
            k++;
        end
        while (q[1:0] !== 2'b00 && k < 60);
    endtask

    // Core state that a master clear returns to zero
    task automatic zero_chk();
        for (int j = 0; j < 7; j++)
            rc("reset value", rz[j], 32'h0);
    endtask

    initial
    begin
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        num_errors = 0;
        n_checks = 0;
        cyc = 0;
        n_srst = 0;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        zero_chk();
        $display("reset values done");
        // Negate over four address forms, with the 00 and 80 edge operands
        apb(1'b1, `NCR_OFF_BANK, 32'h3);
        apb(1'b1, `NCR_OFF_FSR2, 32'h200);
        for (i = 0; i < 4; i++)
        begin
            DMEM.mem[ea[i]] = opv[i];
            apb(1'b1, `NCR_OFF_CTRL, {31'h0, ext[i]});
            run({`NCR_OP_NEG_FILE, abit[i], fo[i]});
            chk("negate result", {24'h0, res[i]}, {24'h0, DMEM.mem[ea[i]]});
            rc("negate flags", `NCR_OFF_FLAGS, {27'h0, flg[i]});
        end
        rc("pc after negates", `NCR_OFF_PC, 32'h8);
        $display("negate done");
        // Rotate into the accumulator, then back into the file with carry set
        apb(1'b1, `NCR_OFF_CTRL, 32'h0);
        run({`NCR_OP_ROT_CARRY, 1'b0, 1'b0, 8'h05});
        rc("rotate acc", `NCR_OFF_ACC, 32'h8C);
        rc("rotate flags", `NCR_OFF_FLAGS, 32'h11);
        run({`NCR_OP_ROT_CARRY, 1'b1, 1'b0, 8'h05});
        chk("rotate file", 32'h8D, {24'h0, DMEM.mem[12'h005]});
        $display("rotate done");
        // Calls at both offset extremes, each undone by a different return
        apb(1'b1, `NCR_OFF_PC, 32'h1000);
        run({`NCR_OP_REL_CALL, 11'h400});
        rc("call pc", `NCR_OFF_PC, 32'h802);
        rc("call stack", `NCR_OFF_STACK, 32'h0100_1002);
        run({`NCR_OP_LIT_RET, 8'h5A});
        rc("literal acc", `NCR_OFF_ACC, 32'h5A);
        rc("literal pc", `NCR_OFF_PC, 32'h1002);
        rc("empty stack", `NCR_OFF_STACK, 32'h0);
        run({`NCR_OP_REL_CALL, 11'h3FF});
        rc("call pc", `NCR_OFF_PC, 32'h1802);
        run({`NCR_OP_IRQ_RET, 1'b0});
        rc("irq enables", `NCR_OFF_IRQEN, 32'h1);
        rc("irq return pc", `NCR_OFF_PC, 32'h1004);
        apb(1'b1, `NCR_OFF_SHADOW, 32'h0007_15AB);
        run({`NCR_OP_REL_CALL, 11'h000});
        run({`NCR_OP_RETURN, 1'b0});
        rc("plain return acc", `NCR_OFF_ACC, 32'h5A);
        rc("plain return pc", `NCR_OFF_PC, 32'h1006);
        run({`NCR_OP_REL_CALL, 11'h000});
        run({`NCR_OP_RETURN, 1'b1});
        rc("fast acc", `NCR_OFF_ACC, 32'hAB);
        rc("fast flags", `NCR_OFF_FLAGS, 32'h15);
        rc("fast bank", `NCR_OFF_BANK, 32'h7);
        rc("fast pc", `NCR_OFF_PC, 32'h1008);
        $display("call and return done");
        // Software reset with nonzero state everywhere but the already empty stack
        run(`NCR_OP_RESET);
        chk("soft reset pulses", 32'h1, n_srst);
        zero_chk();
        // Unknown word and a pop from the empty stack raise sticky status bits
        run(16'h0003);
        run({`NCR_OP_RETURN, 1'b0});
        rc("sticky status", `NCR_OFF_STAT, 32'h1C);
        rc("pc after faults", `NCR_OFF_PC, 32'h0);
        apb(1'b1, `NCR_OFF_STAT, 32'h1C);
        rc("status cleared", `NCR_OFF_STAT, 32'h0);
        $display("software reset done");
        // Refused accesses
        apb(1'b0, 8'h2C, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, e});
        apb(1'b1, `NCR_OFF_STACK, 32'h5);
        chk("stack write error", 32'h1, {31'h0, e});
        $display("bus errors done");
        give_verdict();
    end
endmodule // ncr_exec_tb
`default_nettype wire
